// [inc/lvm_map.svh]
// Purpose: address map, field positions, reset values and timing of the
//          supply monitor control block
// Assumes: 8-bit registers on a 20-bit internal address bus
// Notes:   definitions only
`ifndef LVM_MAP_SVH
`define LVM_MAP_SVH

// register addresses
`define LVM_CTRL_ADDR 20'hF_FFA9
`define LVM_LEVEL_ADDR 20'hF_FFAA

// control register fields
`define LVM_CTRL_WEN_BIT 7
`define LVM_CTRL_MASK_BIT 1
`define LVM_CTRL_BELOW_BIT 0

// level/mode register fields
`define LVM_LEVEL_MODE_BIT 7
`define LVM_LEVEL_SEL_BIT 0

// reset values
`define LVM_CTRL_RST 8'h00
`define LVM_LEVEL_RST_COMBO 8'h00
`define LVM_LEVEL_RST_RESET 8'h81
`define LVM_LEVEL_RST_INT 8'h01

// option byte fields
`define LVM_OPT_MODE_LO_BIT 0
`define LVM_OPT_MODE_HI_BIT 1
`define LVM_OPT_RANGE_HI_BIT 7

// clock rate and comparator settling time
`define LVM_CLK_MHZ 100
`define LVM_SETTLE_NS 300
`define LVM_SETTLE_CYC ((`LVM_SETTLE_NS * `LVM_CLK_MHZ + 999) / 1000)

`endif

// [inc/lvm_pkg.sv]
// Purpose: shared types of the supply monitor control block
// Assumes: nothing
// Notes:   constants live in lvm_map.svh
package lvm_pkg;

   // operating mode taken from the option byte
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_INT,
      MODE_RESET,
      MODE_COMBO
   } mode_t;

   // one internal bus access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [19:0] addr;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } bus_req_t;

endpackage : lvm_pkg

// [rtl/low_voltage_monitor_ctrl.sv]
// Purpose: control logic of the supply voltage monitor: reset, interrupt,
//          level flag, reset cause and the two software registers
// Assumes: comparator outputs are asynchronous levels; option byte is static
// Notes:   resets from other sources arrive on i_rstn; the monitor's own
//          reset leaves these registers untouched
`timescale 1ns/1ps
`include "lvm_map.svh"

// Summary of operation
// - combined mode: upper releases/interrupts, lower resets
// - reset-only mode: reset while below single threshold
// - combined: interrupt below upper, reset below lower
// - interrupt mode: hold reset, then irq both crossings
// - below flag set under threshold, zero when off
// - monitor reset sets low-voltage reset cause flag
// - other resets clear control register to zero
// - control bits 1,0 read-only, bits 6-2 zero
// - level register writable only with write enable
// - combined: mask set by enable or settling
// - mask suppresses interrupt output and a monitor reset held between thresholds
// - level bit 7 selects interrupt/reset, bits 6-1 zero
// - level select zero compares against upper threshold
// - level register reset value from source and mode
// - mode and thresholds come from option byte
// - registers take single-bit and byte writes
// - level select one compares lower/single threshold
// - level resets 00H/81H/01H per mode, not by monitor
// - combined: interrupt sets mode and level bits
module low_voltage_monitor_ctrl #(
   parameter int ADDR_W = 20,
   parameter int SETTLE_CYC = `LVM_SETTLE_CYC
) (
   // clock and reset from other sources
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // option byte, held steady by the flash loader
   input wire logic [7:0] i_option_byte,
   // asynchronous comparator results
   input wire logic i_below_high,
   input wire logic i_below_low,
   // internal bus access
   input wire lvm_pkg::bus_req_t i_bus,
   output logic [7:0] o_bus_rdata,
   // reset cause flag and its clear from the reset-cause register
   input wire logic i_cause_clear,
   output logic o_reset_cause_lv,
   // monitor outputs
   output logic o_lvd_reset,
   output logic o_low_voltage_irq
);

   // refuse settings the address decode or counter cannot serve
   if (ADDR_W != 20)
   begin : g_bad_addr
      $error("ADDR_W must be 20");
   end
   if (SETTLE_CYC < 1 || SETTLE_CYC > 255)
   begin : g_bad_settle
      $error("SETTLE_CYC must be 1..255");
   end

   // merge a masked write into a stored byte, used by the level/mode register
   function automatic logic [7:0] merge_write(input logic [7:0] old_v,
                                              input logic [7:0] wd,
                                              input logic [7:0] wm);
      merge_write = (old_v & ~wm) | (wd & wm);
   endfunction : merge_write

   // reset release synchroniser
   logic rst_meta_q;
   logic rst_sync_q;
   // synchronised reset used by all other logic
   logic rstn_s;

   // reset asserts at once and releases after two edges
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rstn_s = rst_sync_q;

   // comparator synchronisers, first stage read only by second
   logic hi_meta_q;
   logic hi_sync_q;
   logic lo_meta_q;
   logic lo_sync_q;

   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      // reset to below so the start-up hold begins from a low supply,
      // never from a false good reading before the first real sample
      if (!rstn_s)
      begin
         hi_meta_q <= 1'b1;
         hi_sync_q <= 1'b1;
         lo_meta_q <= 1'b1;
         lo_sync_q <= 1'b1;
      end
      else
      begin
         hi_meta_q <= i_below_high;
         hi_sync_q <= hi_meta_q;
         lo_meta_q <= i_below_low;
         lo_sync_q <= lo_meta_q;
      end
   end

   // decoded mode from the option byte
   lvm_pkg::mode_t mode;

   always_comb
   begin
      // range bit high with mode bit 0 set means the monitor is off
      if (i_option_byte[`LVM_OPT_RANGE_HI_BIT] && i_option_byte[`LVM_OPT_MODE_LO_BIT])
      begin
         mode = lvm_pkg::MODE_OFF;
      end
      else
      begin
         unique case (i_option_byte[`LVM_OPT_MODE_HI_BIT:`LVM_OPT_MODE_LO_BIT])
            2'b10: mode = lvm_pkg::MODE_COMBO;
            2'b11: mode = lvm_pkg::MODE_RESET;
            2'b01: mode = lvm_pkg::MODE_INT;
            // 00 is prohibited; treat as off so nothing fires
            default: mode = lvm_pkg::MODE_OFF;
         endcase
      end
   end

   // level/mode reset values per mode, bits picked by field position
   localparam logic [7:0] LEVEL_RST_COMBO = `LVM_LEVEL_RST_COMBO;
   localparam logic [7:0] LEVEL_RST_RESET = `LVM_LEVEL_RST_RESET;
   localparam logic [7:0] LEVEL_RST_INT = `LVM_LEVEL_RST_INT;
   // one cycle after release the mode-dependent reset values load
   logic init_done_q;
   // control register stored bit: write enable
   logic wen_q;
   // level/mode register stored bits
   logic mode_bit_q;
   logic level_sel_q;
   // settling countdown after interrupt or level change
   logic [7:0] settle_q;
   // monitor reset state, also the interrupt-mode start-up hold, and previous comparison
   logic lvd_rst_q;
   logic below_prev_q;
   // mask status seen by software and the outputs
   logic mask_status;
   // comparison against the selected threshold
   logic below_sel;
   // bus write strobes per register
   logic wr_ctrl;
   logic wr_level;
   // next value of level/mode on a software write
   logic [7:0] level_wr_d;
   // interrupt event, already masked in combined mode
   logic irq_event;

   assign wr_ctrl = i_bus.wr && (i_bus.addr == `LVM_CTRL_ADDR);
   assign wr_level = i_bus.wr && (i_bus.addr == `LVM_LEVEL_ADDR);
   assign level_wr_d = merge_write({mode_bit_q, 6'b00_0000, level_sel_q},
                                   i_bus.wdata, i_bus.wmask);

   assign below_sel = level_sel_q ? lo_sync_q : hi_sync_q;

   assign mask_status = (mode == lvm_pkg::MODE_COMBO) && (wen_q || (settle_q != 8'h00));

   // init flag marks that the mode reset values are in place
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         init_done_q <= 1'b0;
      end
      else
      begin
         init_done_q <= 1'b1;
      end
   end

   // write enable bit; i_rstn or a combined-mode write clears it, never the monitor reset
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         wen_q <= 1'b0;
      end
      else if (wr_ctrl && i_bus.wmask[`LVM_CTRL_WEN_BIT] && mode == lvm_pkg::MODE_COMBO)
      begin
         wen_q <= i_bus.wdata[`LVM_CTRL_WEN_BIT];
      end
   end

   // level/mode register: option-dependent value loaded after release
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         mode_bit_q <= 1'b0;
         level_sel_q <= 1'b0;
      end
      else if (!init_done_q)
      begin
         unique case (mode)
            lvm_pkg::MODE_COMBO:
            begin
               mode_bit_q <= LEVEL_RST_COMBO[`LVM_LEVEL_MODE_BIT];
               level_sel_q <= LEVEL_RST_COMBO[`LVM_LEVEL_SEL_BIT];
            end
            lvm_pkg::MODE_RESET:
            begin
               mode_bit_q <= LEVEL_RST_RESET[`LVM_LEVEL_MODE_BIT];
               level_sel_q <= LEVEL_RST_RESET[`LVM_LEVEL_SEL_BIT];
            end
            lvm_pkg::MODE_INT, lvm_pkg::MODE_OFF:
            begin
               mode_bit_q <= LEVEL_RST_INT[`LVM_LEVEL_MODE_BIT];
               level_sel_q <= LEVEL_RST_INT[`LVM_LEVEL_SEL_BIT];
            end
         endcase
      end
      else if (irq_event && mode == lvm_pkg::MODE_COMBO)
      begin
         mode_bit_q <= 1'b1;
         level_sel_q <= 1'b1;
      end
      else if (wr_level && wen_q && mode == lvm_pkg::MODE_COMBO)
      begin
         mode_bit_q <= level_wr_d[`LVM_LEVEL_MODE_BIT];
         level_sel_q <= level_wr_d[`LVM_LEVEL_SEL_BIT];
      end
   end

   // settling countdown; reloads on interrupt or level bit change
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         settle_q <= 8'h00;
      end
      else if ((irq_event && mode == lvm_pkg::MODE_COMBO)
               || (wr_level && wen_q && mode == lvm_pkg::MODE_COMBO
                   && level_wr_d[`LVM_LEVEL_SEL_BIT] != level_sel_q))
      begin
         settle_q <= 8'(SETTLE_CYC);
      end
      else if (settle_q != 8'h00)
      begin
         settle_q <= settle_q - 8'h01;
      end
   end

   // interrupt condition per mode; combined mode already applies the mask
   always_comb
   begin
      irq_event = 1'b0;
      unique case (mode)
         lvm_pkg::MODE_COMBO:
            irq_event = init_done_q && !mode_bit_q && !level_sel_q
                        && hi_sync_q && !below_prev_q && !mask_status;
         lvm_pkg::MODE_INT:
            irq_event = init_done_q && !lvd_rst_q && (lo_sync_q != below_prev_q);
         // reset-only and off modes never interrupt
         lvm_pkg::MODE_RESET, lvm_pkg::MODE_OFF:
            irq_event = 1'b0;
      endcase
   end

   // previous comparison, used for crossing detection
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         // matches the synchronisers' reset level: no false crossing
         below_prev_q <= 1'b1;
      end
      else
      begin
         below_prev_q <= (mode == lvm_pkg::MODE_INT) ? lo_sync_q : hi_sync_q;
      end
   end

   // monitor reset state; asserted from reset until the supply is good, cleared at the first edge when off
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         lvd_rst_q <= 1'b1;
      end
      else
      begin
         unique case (mode)
            lvm_pkg::MODE_COMBO:
            begin
               if (!hi_sync_q)
               begin
                  lvd_rst_q <= 1'b0;
               end
               else if (lo_sync_q)
               begin
                  lvd_rst_q <= 1'b1;
               end
            end
            lvm_pkg::MODE_RESET:
               lvd_rst_q <= lo_sync_q;
            lvm_pkg::MODE_INT:
            begin
               if (!lo_sync_q)
               begin
                  lvd_rst_q <= 1'b0;
               end
            end
            // monitor off: the external reset pin does the job
            lvm_pkg::MODE_OFF:
               lvd_rst_q <= 1'b0;
         endcase
      end
   end

   // mask gates reset output
   // the start-up hold stays visible; the mask only hides a reset held while the supply sits between the thresholds
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         o_lvd_reset <= 1'b1;
      end
      else
      begin
         o_lvd_reset <= lvd_rst_q && !(mask_status && init_done_q && hi_sync_q
                                        && !lo_sync_q);
      end
   end

   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         o_low_voltage_irq <= 1'b0;
      end
      else
      begin
         o_low_voltage_irq <= irq_event && !mask_status;
      end
   end

   // reset cause flag; a new monitor reset beats a clear
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         o_reset_cause_lv <= 1'b0;
      end
      else if (o_lvd_reset && init_done_q && mode != lvm_pkg::MODE_OFF)
      begin
         o_reset_cause_lv <= 1'b1;
      end
      else if (i_cause_clear)
      begin
         o_reset_cause_lv <= 1'b0;
      end
   end

   // registered read data, zero for unmapped addresses
   always_ff @(posedge i_ref_clk or negedge rstn_s)
   begin
      if (!rstn_s)
      begin
         o_bus_rdata <= 8'h00;
      end
      else if (i_bus.rd)
      begin
         if (i_bus.addr == `LVM_CTRL_ADDR)
         begin
            o_bus_rdata <= {wen_q, 5'b0_0000, mask_status,
                            below_sel && mode != lvm_pkg::MODE_OFF};
         end
         else if (i_bus.addr == `LVM_LEVEL_ADDR)
         begin
            o_bus_rdata <= {mode_bit_q, 6'b00_0000, level_sel_q};
         end
         else
         begin
            o_bus_rdata <= 8'h00;
         end
      end
   end

endmodule : low_voltage_monitor_ctrl

// [verification/lvm_ctrl_props.sv]
// Purpose: port checks of the supply monitor control block
// Assumes: option byte only changes while i_rstn is low
// Notes: bound into the block; mode decode mirrors the option byte
`timescale 1ns/1ps
`include "lvm_map.svh"
module lvm_ctrl_props #(
   parameter int ADDR_W = 20,
   parameter int SETTLE_CYC = 30
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // option byte and comparators
   input wire logic [7:0] i_option_byte,
   input wire logic i_below_high,
   input wire logic i_below_low,
   // bus and outputs
   input wire lvm_pkg::bus_req_t i_bus,
   input wire logic [7:0] o_bus_rdata,
   input wire logic i_cause_clear,
   input wire logic o_reset_cause_lv,
   input wire logic o_lvd_reset,
   input wire logic o_low_voltage_irq
);
   // range bit high turns the single-threshold modes off
   wire logic combo = (i_option_byte[1:0] == 2'b10);
   wire logic rst_only = (i_option_byte[1:0] == 2'b11) && !i_option_byte[7];
   wire logic int_only = (i_option_byte[1:0] == 2'b01) && !i_option_byte[7];

   chk_reset_values: assert property (@(posedge i_ref_clk)
      !i_rstn |-> (o_bus_rdata == 8'h00) && o_lvd_reset && !o_low_voltage_irq)
      else $error("outputs not at reset values");
   chk_irq_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_low_voltage_irq |=> !o_low_voltage_irq)
      else $error("irq longer than one cycle");
   chk_combo_irq: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      combo && o_low_voltage_irq |-> $past(i_below_high, 2))
      else $error("combined irq without low supply");
   chk_int_crossing: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      int_only && o_low_voltage_irq |-> $past(i_below_low, 2) != $past(i_below_low, 4))
      else $error("interrupt mode irq without crossing");
   chk_reset_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (rst_only && i_below_low) [*5] |-> o_lvd_reset)
      else $error("reset not raised below threshold");
   chk_reset_release: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (rst_only && !i_below_low) [*8] |-> !o_lvd_reset)
      else $error("reset not released above threshold");
   chk_cause_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $rose(o_lvd_reset) |-> ##[1:2] o_reset_cause_lv)
      else $error("reset cause not recorded");
   chk_ctrl_zeros: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $past(i_bus.rd) && $past(i_bus.addr) == `LVM_CTRL_ADDR |-> o_bus_rdata[6:2] == 5'h00)
      else $error("control bits 6 to 2 not zero");
   chk_level_zeros: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $past(i_bus.rd) && $past(i_bus.addr) == `LVM_LEVEL_ADDR |-> o_bus_rdata[6:1] == 6'h00)
      else $error("level bits 6 to 1 not zero");
endmodule : lvm_ctrl_props

bind low_voltage_monitor_ctrl lvm_ctrl_props #(.ADDR_W(ADDR_W), .SETTLE_CYC(SETTLE_CYC)) props (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_option_byte(i_option_byte),
   .i_below_high(i_below_high), .i_below_low(i_below_low), .i_bus(i_bus),
   .o_bus_rdata(o_bus_rdata), .i_cause_clear(i_cause_clear),
   .o_reset_cause_lv(o_reset_cause_lv), .o_lvd_reset(o_lvd_reset),
   .o_low_voltage_irq(o_low_voltage_irq));

// [verification/lvm_supply_model.sv]
// Purpose: behavioural comparator pair watching a supply in millivolts
// Assumes: lower threshold sits below the upper one
// Notes: outputs move a few ns after the supply, off the clock edge
`timescale 1ns/1ps
module lvm_supply_model #(
   parameter int HIGH_MV = 2900,
   parameter int LOW_MV = 2750,
   parameter int DELAY_NS = 3
) (
   // supply level
   input wire logic [15:0] i_supply_mv,
   // comparator results
   output wire logic o_below_high,
   output wire logic o_below_low
);
   assign #(DELAY_NS) o_below_high = (i_supply_mv < HIGH_MV);
   assign #(DELAY_NS) o_below_low = (i_supply_mv < LOW_MV);
endmodule : lvm_supply_model

// [verification/low_voltage_monitor_ctrl_test.sv]
// Purpose: directed bench of the supply monitor control block
// Assumes: supply model thresholds 2900 mV upper and 2750 mV lower
// Notes: settle count shortened so each dip finishes quickly
`timescale 1ns/1ps
`include "lvm_map.svh"
module low_voltage_monitor_ctrl_test;
   localparam int SETTLE = 4; // short settle window
   localparam logic [19:0] CTRL = `LVM_CTRL_ADDR;
   localparam logic [19:0] LVL = `LVM_LEVEL_ADDR;
   localparam logic [15:0] GOOD = 16'h0CE4; // 3300 mV
   localparam logic [15:0] MID = 16'h0AF0; // 2800 mV, between thresholds
   localparam logic [15:0] LOW = 16'h0A8C; // 2700 mV, below both
   logic i_ref_clk = 1'b0;
   logic i_rstn = 1'b1; // pulled low at the first edge so the reset is an event
   logic [7:0] opt = 8'h12;
   logic cause_clear = 1'b0;
   lvm_pkg::bus_req_t bus = '0;
   logic [15:0] supply = 16'h0CE4;
   wire logic below_high;
   wire logic below_low;
   wire logic [7:0] rdata;
   wire logic cause;
   wire logic lvd_rst;
   wire logic irq;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int irq_count = 0;
   // irq count at the start of a step; only the counter process writes irq_count
   int irq_mark = 0;

   lvm_supply_model supply_cmp (.i_supply_mv(supply), .o_below_high(below_high),
      .o_below_low(below_low));
   low_voltage_monitor_ctrl #(.ADDR_W(20), .SETTLE_CYC(SETTLE)) DUT (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_option_byte(opt),
      .i_below_high(below_high), .i_below_low(below_low), .i_bus(bus),
      .o_bus_rdata(rdata), .i_cause_clear(cause_clear), .o_reset_cause_lv(cause),
      .o_lvd_reset(lvd_rst), .o_low_voltage_irq(irq));

   // 100 MHz clock
   always #5 i_ref_clk = ~i_ref_clk;

   // irq counter and hang guard; the run needs well under 2000 cycles
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (irq === 1'b1)
         irq_count <= irq_count + 1;
      if (cycles == 5000)
      begin
         num_errors = num_errors + 1;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_bit

   // one-cycle write strobe, mask selects bit or byte access
   task automatic bus_write(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge i_ref_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, wmask: m};
      @(posedge i_ref_clk);
      bus <= '0;
   endtask : bus_write

   // read data stands from the cycle after the strobe
   task automatic read_check(input logic [19:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, wmask: 8'h00};
      @(posedge i_ref_clk);
      bus <= '0;
      @(posedge i_ref_clk);
      #1 check_byte(rdata, exp);
   endtask : read_check

   // option byte only changes under reset
   task automatic do_reset(input logic [7:0] o, input logic [15:0] mv);
      @(posedge i_ref_clk);
      i_rstn <= 1'b0;
      opt <= o;
      supply <= mv;
      repeat (16) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
      #1 irq_mark = irq_count;
   endtask : do_reset

   // irq follows three cycles and reset four cycles after a comparator edge
   task automatic set_supply(input logic [15:0] mv);
      @(posedge i_ref_clk);
      supply <= mv;
      repeat (4) @(posedge i_ref_clk);
      #1;
   endtask : set_supply

   // one-cycle clear pulse on the reset cause flag
   task automatic clear_cause();
      @(posedge i_ref_clk);
      cause_clear <= 1'b1;
      @(posedge i_ref_clk);
      cause_clear <= 1'b0;
      @(posedge i_ref_clk);
      #1;
   endtask : clear_cause

   initial
   begin
      // combined mode
      do_reset(8'h12, GOOD);
      read_check(CTRL, 8'h00);
      read_check(LVL, 8'h00);
      bus_write(LVL, 8'h81, 8'hFF);
      read_check(LVL, 8'h00);
      bus_write(CTRL, 8'hFF, 8'hFF);
      read_check(CTRL, 8'h82);
      // a dip while masked stays silent
      set_supply(MID);
      check_byte(8'(irq_count - irq_mark), 8'h00);
      set_supply(GOOD);
      bus_write(LVL, 8'h01, 8'h01);
      read_check(LVL, 8'h01);
      bus_write(LVL, 8'h00, 8'hFF);
      bus_write(CTRL, 8'h00, 8'h80);
      repeat (SETTLE + 4) @(posedge i_ref_clk);
      read_check(CTRL, 8'h00);
      set_supply(MID);
      check_byte(8'(irq_count - irq_mark), 8'h01);
      check_bit(lvd_rst, 1'b0);
      read_check(LVL, 8'h81);
      // start-up hold already set the cause; clear it so the dip must set it again
      clear_cause();
      check_bit(cause, 1'b0);
      set_supply(LOW);
      check_bit(lvd_rst, 1'b1);
      read_check(CTRL, 8'h01);
      check_bit(cause, 1'b1);
      set_supply(MID);
      check_bit(lvd_rst, 1'b1);
      set_supply(GOOD);
      check_bit(lvd_rst, 1'b0);
      read_check(LVL, 8'h81);
      clear_cause();
      check_bit(cause, 1'b0);
      // a reset from outside clears a set write enable
      bus_write(CTRL, 8'h80, 8'h80);
      do_reset(8'h12, GOOD);
      read_check(CTRL, 8'h00);
      // reset-only mode
      do_reset(8'h13, GOOD);
      read_check(LVL, 8'h81);
      bus_write(CTRL, 8'h80, 8'h80);
      read_check(CTRL, 8'h00);
      set_supply(LOW);
      check_bit(lvd_rst, 1'b1);
      read_check(CTRL, 8'h01);
      set_supply(GOOD);
      check_bit(lvd_rst, 1'b0);
      check_byte(8'(irq_count - irq_mark), 8'h00);
      // interrupt-only mode, starting below threshold
      do_reset(8'h11, LOW);
      check_bit(lvd_rst, 1'b1);
      read_check(LVL, 8'h01);
      set_supply(GOOD);
      check_bit(lvd_rst, 1'b0);
      irq_mark = irq_count;
      set_supply(LOW);
      set_supply(GOOD);
      check_byte(8'(irq_count - irq_mark), 8'h02);
      check_bit(lvd_rst, 1'b0);
      // detector off: range bit and mode bit 0 both set
      do_reset(8'h91, LOW);
      read_check(CTRL, 8'h00);
      check_byte(8'(irq_count - irq_mark), 8'h00);
      check_bit(lvd_rst, 1'b0);
      check_bit(cause, 1'b0);
      stop_test();
   end
endmodule : low_voltage_monitor_ctrl_test
